// ### include/dsp_decode_map.vh
// Purpose: Constants for the instruction word decoder: classes, states, field positions.
// Assumes: 16-bit program words, high byte selects most instruction forms.
// Notes:   Class codes are internal; zero means the word is not decoded here.
`ifndef DSP_DECODE_MAP_VH
`define DSP_DECODE_MAP_VH

`define WORD_W            16
`define CLASS_W           6
`define CYC_W             2
`define PC_RESET          16'h0000
`define STATUS_RESET      8'h00
`define PM_RESET          2'h0

// Fields of the addressed-data and immediate forms
`define IND_BIT           7
`define ADDR_HI           6
`define STBIT_SEL_HI      3
`define STBIT_SEL_LO      1
`define STBIT_VAL         0
`define BITPOS_HI         11
`define BITPOS_LO         8
`define MPYIMM_HI         12
`define SHORT_HI          7

// Decoded instruction classes
`define CLS_UNKNOWN       6'h00
`define CLS_BMOV_DD       6'h01
`define CLS_BMOV_DD_BLOCK_MOVE_ADDR_REG  6'h02
`define CLS_BMOV_DP       6'h03
`define CLS_BMOV_PD       6'h04
`define CLS_BMOV_PD_BLOCK_MOVE_ADDR_REG  6'h05
`define CLS_DMOVE         6'h06
`define CLS_AND_DBM       6'h07
`define CLS_AND_LK        6'h08
`define CLS_CMP_DBM       6'h09
`define CLS_CMP_LK        6'h0a
`define CLS_OR_DBM        6'h0b
`define CLS_OR_LK         6'h0c
`define CLS_XOR_DBM       6'h0d
`define CLS_XOR_LK        6'h0e
`define CLS_STORE_LK      6'h0f
`define CLS_MACC          6'h10
`define CLS_MACC_SHIFT    6'h11
`define CLS_MACC_IND      6'h12
`define CLS_MACC_IND_MOV  6'h13
`define CLS_MPY_IMM       6'h14
`define CLS_MPY_UNS       6'h15
`define CLS_LT_ACC_MOV    6'h16
`define CLS_PSHIFT_SET    6'h17
`define CLS_STATUS_BIT    6'h18
`define CLS_BIT_TEST      6'h19
`define CLS_ST_LOAD0      6'h1a
`define CLS_ST_LOAD1      6'h1b
`define CLS_ST_STORE0     6'h1c
`define CLS_ST_STORE1     6'h1d
`define CLS_RPT_DATA      6'h1e
`define CLS_RPT_SHORT     6'h1f
`define CLS_RPT_LONG      6'h20
`define CLS_RPT_CLEAR     6'h21
`define CLS_PUSH_DATA     6'h22
`define CLS_POP_DATA      6'h23

// Sequencer states, one-hot
`define ST_FETCH          3'b001
`define ST_OPND           3'b010
`define ST_EXEC           3'b100

`endif

// ### verification/dsp_decoder_checker_assertions.sv
// Purpose: Port-level timing and field checks for the opcode decoder.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Timing checks count only enabled edges; frozen cycles hold state.
`include "dsp_decode_map.vh"
`default_nettype none
module dsp_decoder_checker (
  input wire logic                REF_CLK,
  input wire logic                RESET,
  input wire logic                CLK_EN,
  input wire logic                PROG_ACK,
  input wire logic [`WORD_W-1:0]  PROG_ADDR,
  input wire logic                PROG_RD,
  input wire logic                OP_VALID,
  input wire logic [`CLASS_W-1:0] OP_CLASS,
  input wire logic [`CYC_W-1:0]   OP_CYCLES,
  input wire logic [`WORD_W-1:0]  OP_WORD,
  input wire logic                OP_INDIRECT,
  input wire logic [6:0]          OP_ADDR_FIELD,
  input wire logic [12:0]         OP_MPY_IMM,
  input wire logic [3:0]          OP_BIT_POS,
  input wire logic [1:0]          PROD_SHIFT_MODE,
  input wire logic [7:0]          STATUS_BITS,
  input wire logic                RPT_CLEAR_PULSE,
  input wire logic                EXEC_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  valid_one_cycle_a: assert property (OP_VALID && CLK_EN |=> !OP_VALID)
    else $error("decode pulse longer than one cycle");
  fetch_step_a: assert property (PROG_RD && PROG_ACK && CLK_EN |=>
    !PROG_RD && PROG_ADDR == $past(PROG_ADDR) + 16'h0001) else $error("bad fetch step");
  busy_start_a: assert property (OP_VALID |-> EXEC_BUSY == (OP_CYCLES != 2'h1))
    else $error("busy flag wrong at decode");
  busy_three_a: assert property (OP_VALID && CLK_EN && OP_CYCLES == 2'h3 |=>
    EXEC_BUSY ##1 (!EXEC_BUSY || !$past(CLK_EN))) else $error("three cycle hold wrong");
  busy_two_a: assert property (OP_VALID && CLK_EN && OP_CYCLES == 2'h2 |=> !EXEC_BUSY)
    else $error("two cycle hold wrong");
  busy_no_fetch_a: assert property (EXEC_BUSY |-> !PROG_RD)
    else $error("fetch during hold");
  addr_fields_a: assert property (OP_VALID |-> OP_INDIRECT == OP_WORD[7] &&
    OP_ADDR_FIELD == OP_WORD[6:0] && OP_BIT_POS == OP_WORD[11:8]) else $error("bad fields");
  mpy_imm_a: assert property (OP_VALID && OP_WORD[15:13] == 3'b110 |->
    OP_CLASS == `CLS_MPY_IMM && OP_MPY_IMM == OP_WORD[12:0]) else $error("bad multiply");
  status_bit_a: assert property (OP_VALID && OP_WORD[15:4] == 12'hbe4 |->
    STATUS_BITS[OP_WORD[3:1]] == OP_WORD[0]) else $error("status bit not updated");
  shift_mode_a: assert property (OP_VALID && OP_WORD[15:2] == 14'h2fc0 |->
    PROD_SHIFT_MODE == OP_WORD[1:0]) else $error("shift mode not updated");
  clear_pulse_a: assert property (RPT_CLEAR_PULSE |-> OP_VALID &&
    OP_WORD == 16'hbec5) else $error("stray clear pulse");
endmodule
bind dsp_opcode_decoder dsp_decoder_checker chk_u (.REF_CLK, .RESET, .CLK_EN, .PROG_ACK,
  .PROG_ADDR, .PROG_RD, .OP_VALID, .OP_CLASS, .OP_CYCLES, .OP_WORD, .OP_INDIRECT,
  .OP_ADDR_FIELD, .OP_MPY_IMM, .OP_BIT_POS, .PROD_SHIFT_MODE, .STATUS_BITS,
  .RPT_CLEAR_PULSE, .EXEC_BUSY);
`default_nettype wire

// ### verification/dsp_opcode_decoder_mem_logic_ctrl_tb.sv
// Purpose: Runs every covered opcode through the decoder and checks each decode.
// Assumes: Program loaded while reset is held; two runs, prompt then slow memory.
// Notes:   Table entry: word, class, flags (bit0 two words, bit1 random low byte), cycles.
`include "dsp_decode_map.vh"
`default_nettype none
`define CHECK(a, b, m) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t %s", $time, m); end end
module dsp_opcode_decoder_mem_logic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        CLK_EN = 1'b1;
  logic        slow = 1'b0;
  logic [15:0] PROG_DATA, PROG_ADDR, OP_WORD, OP_LONG_WORD, RPT_COUNT, pc;
  logic        PROG_ACK, PROG_RD, OP_VALID, OP_UNKNOWN, OP_TWO_WORD, OP_INDIRECT;
  logic        RPT_CLEAR_PULSE, EXEC_BUSY;
  logic [5:0]  OP_CLASS;
  logic [1:0]  OP_CYCLES, PROD_SHIFT_MODE;
  logic [6:0]  OP_ADDR_FIELD;
  logic [12:0] OP_MPY_IMM;
  logic [3:0]  OP_BIT_POS;
  logic [7:0]  STATUS_BITS;
  logic [56:0] n;
  logic [7:0]  exp_status;
  logic [1:0]  exp_mode;
  logic [56:0] notes [$];
  int          miscompares = 0;
  int          tests_run = 0;
  int          seed = 11974;
  logic [31:0] tbl [35] = '{32'ha800_0133, 32'hac00_0222, 32'h5700_0322, 32'ha500_0433,
    32'ha400_0522, 32'h7700_0621, 32'h5a00_0721, 32'h5e00_0832, 32'h5b00_0921,
    32'h5f00_0a32, 32'h5900_0b21, 32'h5d00_0c32, 32'h5800_0d21, 32'h5c00_0e32,
    32'hae00_0f32, 32'ha200_1033, 32'ha300_1133, 32'haa00_1223, 32'hab00_1323,
    32'hc000_1421, 32'hdfff_1401, 32'h5500_1521, 32'h7200_1621, 32'h0e00_1a22,
    32'h0f00_1b22, 32'h8e00_1c21, 32'h8f00_1d21, 32'h0b00_1e22, 32'hbb00_1f22,
    32'h7600_2221, 32'h8a00_2321, 32'h4a00_1921, 32'hbec4_2012, 32'hbec5_2112,
    32'h6c00_0021};

  dsp_opcode_decoder dut_u (.REF_CLK, .RESET, .CLK_EN, .PROG_DATA, .PROG_ACK, .PROG_ADDR,
    .PROG_RD, .OP_VALID, .OP_CLASS, .OP_UNKNOWN, .OP_TWO_WORD, .OP_CYCLES, .OP_WORD,
    .OP_LONG_WORD, .OP_INDIRECT, .OP_ADDR_FIELD, .OP_MPY_IMM, .OP_BIT_POS,
    .PROD_SHIFT_MODE, .STATUS_BITS, .RPT_COUNT, .RPT_CLEAR_PULSE, .EXEC_BUSY);
  prog_mem_model mem_u (.clk(REF_CLK), .rst(RESET), .en(CLK_EN), .slow(slow),
    .rd(PROG_RD), .addr(PROG_ADDR), .data(PROG_DATA), .ack(PROG_ACK));

  always #10 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) CLK_EN <= slow ? (($random(seed) & 3) != 0) : 1'b1;

  task automatic add(input logic [15:0] w, input logic [5:0] c, input logic t,
                     input logic [1:0] y);
    logic [15:0] l;
    l = t ? 16'($random(seed)) : 16'h0000;
    mem_u.mem[pc[7:0]] = w;
    if (t) mem_u.mem[pc[7:0] + 8'h01] = l;
    pc = pc + 16'h0001 + {15'h0000, t};
    notes.push_back({pc, w, l, c, t, y});
  endtask

  task automatic run_pass(input logic sl);
    int          i;
    logic [15:0] w;
    RESET <= 1'b1;
    slow <= sl;
    pc = 16'h0000;
    notes.delete();
    exp_status = 8'h00;
    exp_mode = 2'h0;
    for (i = 0; i < 35; i++) begin
      w = tbl[i][31:16];
      if (tbl[i][5]) w[7:0] = 8'($random(seed));
      add(w, tbl[i][13:8], tbl[i][4], tbl[i][1:0]);
    end
    for (i = 0; i < 16; i++) add(16'hbe40 + 16'(i), `CLS_STATUS_BIT, 1'b0, 2'h1);
    for (i = 0; i < 4; i++) add(16'hbf00 + 16'(i), `CLS_PSHIFT_SET, 1'b0, 2'h1);
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    i = 0;
    while (notes.size() > 0 && i < 3000) begin
      @(posedge REF_CLK);
      i++;
    end
    RESET <= 1'b1;
    `CHECK(notes.size(), 0, "decodes missing")
    $display("Run with slow memory %0d finished", sl);
  endtask

  always @(posedge REF_CLK) begin
    if (!RESET && OP_VALID === 1'b1 && CLK_EN) begin
      if (notes.size() == 0) `CHECK(1'b1, 1'b0, "unexpected decode")
      else begin
        n = notes.pop_front();
        `CHECK(OP_WORD, n[40:25], "first word")
        `CHECK(OP_CLASS, n[8:3], "class")
        `CHECK(OP_TWO_WORD, n[2], "word count")
        `CHECK(OP_CYCLES, n[1:0], "cycle count")
        `CHECK(OP_LONG_WORD, n[24:9], "second word")
        `CHECK(PROG_ADDR, n[56:41], "program counter")
        `CHECK(OP_UNKNOWN, n[8:3] == `CLS_UNKNOWN, "unknown flag")
        `CHECK(OP_INDIRECT, n[32], "indirect flag")
        `CHECK(OP_ADDR_FIELD, n[31:25], "address field")
        `CHECK(OP_MPY_IMM, n[37:25], "multiply immediate")
        `CHECK(OP_BIT_POS, n[36:33], "bit position")
        `CHECK(EXEC_BUSY, n[1:0] != 2'h1, "busy at decode")
        `CHECK(RPT_CLEAR_PULSE, n[8:3] == `CLS_RPT_CLEAR, "clear pulse")
        if (n[8:3] == `CLS_STATUS_BIT) exp_status[n[28:26]] = n[25];
        if (n[8:3] == `CLS_PSHIFT_SET) exp_mode = n[26:25];
        `CHECK(STATUS_BITS, exp_status, "status bits")
        `CHECK(PROD_SHIFT_MODE, exp_mode, "shift mode")
        if (n[8:3] == `CLS_RPT_LONG || n[8:3] == `CLS_RPT_CLEAR)
          `CHECK(RPT_COUNT, n[24:9], "long repeat count")
        if (n[8:3] == `CLS_RPT_SHORT)
          `CHECK(RPT_COUNT, {8'h00, n[32:25]}, "short repeat count")
      end
    end
  end

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    run_pass(1'b0);
    run_pass(1'b1);
    give_verdict();
  end

  // Each run is capped at 3000 cycles; allow 10000
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ### verification/prog_mem_model.sv
// Purpose: Program memory answering fetches with a word and an acknowledge.
// Assumes: Request held until taken; answer held until taken.
// Notes:   Slow mode inserts 0 to 3 wait cycles per word.
`default_nettype none
module prog_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en,
  input  wire logic        slow,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  output var  logic [15:0] data,
  output var  logic        ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [1:0]  wait_cnt;
  int          seed = 11974;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      data <= 16'h5a5a;
      wait_cnt <= 2'h0;
    end else if (en) begin
      if (ack && rd) begin
        ack <= 1'b0;
        data <= ~data;
        wait_cnt <= slow ? 2'($random(seed)) : 2'h0;
      end else if (rd && wait_cnt == 2'h0) begin
        ack <= 1'b1;
        data <= mem[addr[7:0]];
      end else begin
        // No stale word left on an idle bus
        data <= ~data;
        wait_cnt <= (wait_cnt != 2'h0) ? wait_cnt - 2'h1 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/dsp_opcode_decoder.v
// Purpose: Fetch and decode of data-move, logic, multiply and control instruction words.
// Assumes: Program bus answers a read with PROG_ACK in the cycle the word is on PROG_DATA.
// Notes:   Words outside the covered groups decode as unknown, one word, one cycle.
//
// Summary of operation
// - High byte a8 is data-to-data block move, two words, three cycles.
// - High byte ac is one-word data block move, source from move register, two cycles.
// - High byte 57 is data-to-program block move, one word, two cycles.
// - High byte a5 program-to-data move, two words three cycles; a4 one word two.
// - High byte 77 is in-data word move, one word, one cycle.
// - AND with bit mask register 5a one cycle; long immediate 5e two words, two.
// - Compare with bit mask register 5b one cycle; long immediate 5f two words, two.
// - OR with bit mask register 59 one cycle; long immediate 5d two words, two.
// - XOR with bit mask register 58 one cycle; long immediate 5c two words, two.
// - High byte ae stores long immediate to data, two words, two cycles.
// - Multiply-accumulate a2 and with data shift a3, two words, three cycles.
// - Indirect multiply-accumulate aa and with move ab, one word, three cycles.
// - Top bits 110 multiply temp register zero by 13-bit signed immediate.
// - High byte 55 is unsigned multiply, one word, one cycle.
// - High byte 72 loads temp register, accumulates product, moves data, one cycle.
// - Word bf0 with two-bit field sets product shift mode, one cycle.
// - Prefix be4 sets or clears one of eight status bits, bit 0 chooses.
// - Top nibble 4 tests bit chosen by next four bits, one cycle.
// - Status load 0e/0f two cycles; status store 8e/8f one cycle.
// - Repeat forms 0b, bb and bec4 take two cycles; bec4 has two words.
// - Word bec5 clears accumulator and product then repeats, two words, two cycles.
// - Push data to stack 76 and pop stack to data 8a, one cycle each.
`include "dsp_decode_map.vh"
`default_nettype none

module dsp_opcode_decoder #(
  parameter WORD_W = `WORD_W
) (
  input  wire              REF_CLK,
  input  wire              RESET,
  input  wire              CLK_EN,
  input  wire [WORD_W-1:0] PROG_DATA,
  input  wire              PROG_ACK,
  output reg  [WORD_W-1:0] PROG_ADDR,
  output reg               PROG_RD,
  output reg               OP_VALID,
  output reg  [`CLASS_W-1:0] OP_CLASS,
  output reg               OP_UNKNOWN,
  output reg               OP_TWO_WORD,
  output reg  [`CYC_W-1:0] OP_CYCLES,
  output reg  [WORD_W-1:0] OP_WORD,
  output reg  [WORD_W-1:0] OP_LONG_WORD,
  output reg               OP_INDIRECT,
  output reg  [6:0]        OP_ADDR_FIELD,
  output reg  [12:0]       OP_MPY_IMM,
  output reg  [3:0]        OP_BIT_POS,
  output reg  [1:0]        PROD_SHIFT_MODE,
  output reg  [7:0]        STATUS_BITS,
  output reg  [WORD_W-1:0] RPT_COUNT,
  output reg               RPT_CLEAR_PULSE,
  output reg               EXEC_BUSY
);

  localparam [2:0] S_FETCH = `ST_FETCH;
  localparam [2:0] S_OPND  = `ST_OPND;
  localparam [2:0] S_EXEC  = `ST_EXEC;

  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg  [WORD_W-1:0]   first_word;
  reg  [`CYC_W-1:0]   cyc_left;

  wire [WORD_W-1:0]   dec_word;
  wire [`CLASS_W-1:0] tbl_cls;
  wire                tbl_two;
  wire [`CYC_W-1:0]   tbl_cyc;
  wire                take_first;
  wire                take_last;
  wire [WORD_W-1:0]   last_long;
  wire [2:0]          stbit_sel;
  wire                stbit_val;

  // First word is looked up straight off the bus; the held copy serves the operand cycle
  assign dec_word   = (state == S_OPND) ? first_word : PROG_DATA;
  assign take_first = (state == S_FETCH) && PROG_RD && PROG_ACK;
  assign take_last  = (take_first && !tbl_two) ||
                      ((state == S_OPND) && PROG_RD && PROG_ACK);
  assign last_long  = (state == S_OPND) ? PROG_DATA : {WORD_W{1'b0}};
  assign stbit_sel  = dec_word[`STBIT_SEL_HI:`STBIT_SEL_LO];
  assign stbit_val  = dec_word[`STBIT_VAL];

  dsp_opcode_table u_table (
    .word     (dec_word),
    .cls      (tbl_cls),
    .two_word (tbl_two),
    .cycles   (tbl_cyc)
  );

  // Sequencer: fetch, optional operand fetch, then hold for the remaining cycles
  always @* begin
    next_state = state;
    case (state)
      S_FETCH: begin
        if (take_first && tbl_two) begin
          next_state = S_OPND;
        end else if (take_last && tbl_cyc > 2'd1) begin
          next_state = S_EXEC;
        end
      end
      S_OPND: begin
        if (take_last) begin
          if (tbl_cyc > 2'd1) begin
            next_state = S_EXEC;
          end else begin
            next_state = S_FETCH;
          end
        end
      end
      S_EXEC: begin
        if (cyc_left == 2'd1) begin
          next_state = S_FETCH;
        end
      end
      default: begin
        next_state = S_FETCH;
      end
    endcase
  end

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state <= S_FETCH;
      first_word <= {WORD_W{1'b0}};
      cyc_left <= 2'd0;
      PROG_ADDR <= `PC_RESET;
      PROG_RD <= 1'b0;
    end else if (CLK_EN) begin
      state <= next_state;
      // Read strobe only while a word is wanted; it drops for the taken word's next cycle
      PROG_RD <= (next_state != S_EXEC) && !(PROG_RD && PROG_ACK);
      if (PROG_RD && PROG_ACK) begin
        PROG_ADDR <= PROG_ADDR + {{(WORD_W-1){1'b0}}, 1'b1};
      end
      if (take_first) begin
        first_word <= PROG_DATA;
      end
      if (take_last) begin
        cyc_left <= tbl_cyc - 2'd1;
      end else if (state == S_EXEC && cyc_left != 2'd0) begin
        cyc_left <= cyc_left - 2'd1;
      end
    end
  end

  // Decoded outputs, loaded once the last word of an instruction is in
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      OP_VALID <= 1'b0;
      OP_CLASS <= `CLS_UNKNOWN;
      OP_UNKNOWN <= 1'b0;
      OP_TWO_WORD <= 1'b0;
      OP_CYCLES <= 2'd0;
      OP_WORD <= {WORD_W{1'b0}};
      OP_LONG_WORD <= {WORD_W{1'b0}};
      OP_INDIRECT <= 1'b0;
      OP_ADDR_FIELD <= 7'h00;
      OP_MPY_IMM <= 13'h0000;
      OP_BIT_POS <= 4'h0;
      EXEC_BUSY <= 1'b0;
      RPT_CLEAR_PULSE <= 1'b0;
    end else if (CLK_EN) begin
      OP_VALID <= take_last;
      RPT_CLEAR_PULSE <= take_last && (tbl_cls == `CLS_RPT_CLEAR);
      EXEC_BUSY <= (next_state == S_EXEC);
      if (take_last) begin
        OP_CLASS <= tbl_cls;
        OP_UNKNOWN <= (tbl_cls == `CLS_UNKNOWN);
        OP_TWO_WORD <= tbl_two;
        OP_CYCLES <= tbl_cyc;
        OP_WORD <= dec_word;
        OP_LONG_WORD <= last_long;
        OP_INDIRECT <= dec_word[`IND_BIT];
        OP_ADDR_FIELD <= dec_word[`ADDR_HI:0];
        OP_MPY_IMM <= dec_word[`MPYIMM_HI:0];
        OP_BIT_POS <= dec_word[`BITPOS_HI:`BITPOS_LO];
      end
    end
  end

  // Architectural side effects that the decoder owns
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      PROD_SHIFT_MODE <= `PM_RESET;
      STATUS_BITS <= `STATUS_RESET;
      RPT_COUNT <= {WORD_W{1'b0}};
    end else if (CLK_EN && take_last) begin
      case (tbl_cls)
        `CLS_PSHIFT_SET: begin
          PROD_SHIFT_MODE <= dec_word[1:0];
        end
        `CLS_STATUS_BIT: begin
          // Index 0 interrupt mask ... 7 carry; low bit is the new value
          STATUS_BITS[stbit_sel] <= stbit_val;
        end
        `CLS_RPT_SHORT: begin
          RPT_COUNT <= {{(WORD_W-8){1'b0}}, dec_word[`SHORT_HI:0]};
        end
        `CLS_RPT_LONG: begin
          RPT_COUNT <= last_long;
        end
        `CLS_RPT_CLEAR: begin
          RPT_COUNT <= last_long;
        end
        default: begin
          RPT_COUNT <= RPT_COUNT;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### verilog/dsp_opcode_table.v
// Purpose: Combinational lookup of class, word count and cycle count for one opcode word.
// Assumes: Word is the first word of an instruction.
// Notes:   Overlapping patterns resolved by casez order, most specific first.
`include "dsp_decode_map.vh"
`default_nettype none

module dsp_opcode_table (
  input  wire [`WORD_W-1:0]  word,
  output wire [`CLASS_W-1:0] cls,
  output wire                two_word,
  output wire [`CYC_W-1:0]   cycles
);

  reg [`CLASS_W+`CYC_W:0] entry;

  assign cls      = entry[`CLASS_W+`CYC_W:`CYC_W+1];
  assign two_word = entry[`CYC_W];
  assign cycles   = entry[`CYC_W-1:0];

  // Entry is {class, two-word flag, cycle count}
  always @* begin
    casez (word)
      16'b1011_1110_1100_0100: entry = {`CLS_RPT_LONG, 1'b1, 2'd2};
      16'b1011_1110_1100_0101: entry = {`CLS_RPT_CLEAR, 1'b1, 2'd2};
      16'b1011_1110_0100_????: entry = {`CLS_STATUS_BIT, 1'b0, 2'd1};
      16'b1011_1111_0000_00??: entry = {`CLS_PSHIFT_SET, 1'b0, 2'd1};
      16'b110?_????_????_????: entry = {`CLS_MPY_IMM, 1'b0, 2'd1};
      16'b0100_????_????_????: entry = {`CLS_BIT_TEST, 1'b0, 2'd1};
      16'b1010_1000_????_????: entry = {`CLS_BMOV_DD, 1'b1, 2'd3};
      16'b1010_1100_????_????: entry = {`CLS_BMOV_DD_BLOCK_MOVE_ADDR_REG, 1'b0, 2'd2};
      16'b0101_0111_????_????: entry = {`CLS_BMOV_DP, 1'b0, 2'd2};
      16'b1010_0101_????_????: entry = {`CLS_BMOV_PD, 1'b1, 2'd3};
      16'b1010_0100_????_????: entry = {`CLS_BMOV_PD_BLOCK_MOVE_ADDR_REG, 1'b0, 2'd2};
      16'b0111_0111_????_????: entry = {`CLS_DMOVE, 1'b0, 2'd1};
      16'b0101_1010_????_????: entry = {`CLS_AND_DBM, 1'b0, 2'd1};
      16'b0101_1110_????_????: entry = {`CLS_AND_LK, 1'b1, 2'd2};
      16'b0101_1011_????_????: entry = {`CLS_CMP_DBM, 1'b0, 2'd1};
      16'b0101_1111_????_????: entry = {`CLS_CMP_LK, 1'b1, 2'd2};
      16'b0101_1001_????_????: entry = {`CLS_OR_DBM, 1'b0, 2'd1};
      16'b0101_1101_????_????: entry = {`CLS_OR_LK, 1'b1, 2'd2};
      16'b0101_1000_????_????: entry = {`CLS_XOR_DBM, 1'b0, 2'd1};
      16'b0101_1100_????_????: entry = {`CLS_XOR_LK, 1'b1, 2'd2};
      16'b1010_1110_????_????: entry = {`CLS_STORE_LK, 1'b1, 2'd2};
      16'b1010_0010_????_????: entry = {`CLS_MACC, 1'b1, 2'd3};
      16'b1010_0011_????_????: entry = {`CLS_MACC_SHIFT, 1'b1, 2'd3};
      16'b1010_1010_????_????: entry = {`CLS_MACC_IND, 1'b0, 2'd3};
      16'b1010_1011_????_????: entry = {`CLS_MACC_IND_MOV, 1'b0, 2'd3};
      16'b0101_0101_????_????: entry = {`CLS_MPY_UNS, 1'b0, 2'd1};
      16'b0111_0010_????_????: entry = {`CLS_LT_ACC_MOV, 1'b0, 2'd1};
      16'b0000_1110_????_????: entry = {`CLS_ST_LOAD0, 1'b0, 2'd2};
      16'b0000_1111_????_????: entry = {`CLS_ST_LOAD1, 1'b0, 2'd2};
      16'b1000_1110_????_????: entry = {`CLS_ST_STORE0, 1'b0, 2'd1};
      16'b1000_1111_????_????: entry = {`CLS_ST_STORE1, 1'b0, 2'd1};
      16'b0000_1011_????_????: entry = {`CLS_RPT_DATA, 1'b0, 2'd2};
      16'b1011_1011_????_????: entry = {`CLS_RPT_SHORT, 1'b0, 2'd2};
      16'b0111_0110_????_????: entry = {`CLS_PUSH_DATA, 1'b0, 2'd1};
      16'b1000_1010_????_????: entry = {`CLS_POP_DATA, 1'b0, 2'd1};
      default:                 entry = {`CLS_UNKNOWN, 1'b0, 2'd1};
    endcase
  end

endmodule

`default_nettype wire
